// ---- rtl/bsd_defines.vh ----
// Constants shared by the branch and system-control execution block.
// Assumes the including file supplies the timescale and module context.
`ifndef BSD_DEFINES_VH
`define BSD_DEFINES_VH

// Primary operation field, always the leading four bits of the first word.
`define BSD_OP_BRANCH 4'h0
`define BSD_OP_JUMP 4'h1
`define BSD_OP_CALL_REL 4'h2
`define BSD_OP_CALL_ABS 4'h3
`define BSD_OP_RET_SUB 4'h4
`define BSD_OP_TRAP 4'h5
`define BSD_OP_RET_EXC 4'h6
`define BSD_OP_SLEEP 4'h7
`define BSD_OP_LOAD_FLAGS 4'h8
`define BSD_OP_STORE_FLAGS 4'h9
`define BSD_OP_AND_FLAGS 4'ha
`define BSD_OP_OR_FLAGS 4'hb
`define BSD_OP_XOR_FLAGS 4'hc
`define BSD_OP_NOP 4'hd
`define BSD_OP_SECOND 4'hf

// Second operation field, bits 11..8, used under BSD_OP_SECOND.
`define BSD_OP2_MOVE_BYTE 4'h0
`define BSD_OP2_MOVE_WORD 4'h1

// Modifier bits inside bits 11..8 of the flag-register instructions.
`define BSD_SEL_EXT_BIT 11
`define BSD_SEL_MEM_BIT 10

// Branch condition field codes.
`define BSD_CC_ALWAYS 4'h0
`define BSD_CC_NEVER 4'h1
`define BSD_CC_HIGHER 4'h2
`define BSD_CC_LOWER_SAME 4'h3
`define BSD_CC_CARRY_CLEAR 4'h4
`define BSD_CC_CARRY_SET 4'h5
`define BSD_CC_NOT_EQUAL 4'h6
`define BSD_CC_EQUAL 4'h7
`define BSD_CC_OVF_CLEAR 4'h8
`define BSD_CC_OVF_SET 4'h9
`define BSD_CC_PLUS 4'ha
`define BSD_CC_MINUS 4'hb
`define BSD_CC_SIGNED_GE 4'hc
`define BSD_CC_SIGNED_LT 4'hd
`define BSD_CC_SIGNED_GT 4'he
`define BSD_CC_SIGNED_LE 4'hf

// Flag positions inside the condition-code register.
`define BSD_FLAG_C 0
`define BSD_FLAG_V 1
`define BSD_FLAG_Z 2
`define BSD_FLAG_N 3

// Extension word size codes.
`define BSD_EXT_NONE 2'h0
`define BSD_EXT_8 2'h1
`define BSD_EXT_16 2'h2
`define BSD_EXT_32 2'h3

// Instruction unit and pointer steps, in bytes.
`define BSD_WORD_BYTES 24'h000002
`define BSD_EXT16_BYTES 24'h000002
`define BSD_EXT32_BYTES 24'h000004
`define BSD_PTR_STEP 32'h00000001

// Execution states.
`define BSD_ST_READY 3'h0
`define BSD_ST_VEC_RD 3'h1
`define BSD_ST_FLAG_RD 3'h2
`define BSD_ST_FLAG_WR 3'h3
`define BSD_ST_MOVE_RD 3'h4
`define BSD_ST_MOVE_WR 3'h5
`define BSD_ST_SLEEP 3'h6

// Reset values and vector table placement.
`define BSD_PC_RESET 24'h000000
`define BSD_CCR_RESET 8'h80
`define BSD_EXR_RESET 8'h00
`define BSD_TRAP_VEC_BASE 24'h000020
`define BSD_RS_DEPTH 4
`define BSD_RS_PTR_W 2

`endif

// ---- rtl/bsd_cond_eval.v ----
// Combinational evaluator of the sixteen branch conditions.
// Assumes the caller hands it the up-to-date condition-code byte.
`timescale 1ns/1ps
`include "bsd_defines.vh"

module bsd_cond_eval (
    input wire [3:0] cond_i,
    input wire [7:0] flags_i,
    output reg true_o
);
    wire c = flags_i[`BSD_FLAG_C];
    wire v = flags_i[`BSD_FLAG_V];
    wire z = flags_i[`BSD_FLAG_Z];
    wire n = flags_i[`BSD_FLAG_N];

    always @* begin
        case (cond_i)
            `BSD_CC_ALWAYS: true_o = 1'b1;
            `BSD_CC_NEVER: true_o = 1'b0;
            `BSD_CC_HIGHER: true_o = ((c | z) == 1'b0);
            `BSD_CC_LOWER_SAME: true_o = ((c | z) == 1'b1);
            `BSD_CC_CARRY_CLEAR: true_o = (c == 1'b0);
            `BSD_CC_CARRY_SET: true_o = (c == 1'b1);
            `BSD_CC_NOT_EQUAL: true_o = (z == 1'b0);
            `BSD_CC_EQUAL: true_o = (z == 1'b1);
            `BSD_CC_OVF_CLEAR: true_o = (v == 1'b0);
            `BSD_CC_OVF_SET: true_o = (v == 1'b1);
            `BSD_CC_PLUS: true_o = (n == 1'b0);
            `BSD_CC_MINUS: true_o = (n == 1'b1);
            `BSD_CC_SIGNED_GE: true_o = ((n ^ v) == 1'b0);
            `BSD_CC_SIGNED_LT: true_o = ((n ^ v) == 1'b1);
            `BSD_CC_SIGNED_GT: true_o = ((z | (n ^ v)) == 1'b0);
            `BSD_CC_SIGNED_LE: true_o = ((z | (n ^ v)) == 1'b1);
            default: true_o = 1'b0;
        endcase
    end
endmodule

// ---- rtl/bsd_exec_ctl.v ----
// Execution control for branches, system control and block moves.
// Assumes assembled operands arrive with each instruction and memory acks each request.
// What this block does
// - Conditional branch jumps only if condition true; always/never fixed.
// - Unsigned conditions use carry, and carry OR zero.
// - Single-flag conditions test zero, overflow or negative directly.
// - Signed conditions use negative XOR overflow, optionally ORed with zero.
// - Unconditional jump always loads its target, flags ignored.
// - Both call forms jump to target and save the return address.
// - Subroutine return resumes at the address saved by the call.
// - Trap enters exception handling through the vector it selects.
// - Exception return restores the interrupted program flow.
// - Sleep enters power-down instead of running the next instruction.
// - Load to flag register copies source; memory source read by word.
// - Store of flag or extended register; memory target written by word.
// - AND, OR, XOR immediate combine into flag or extended register.
// - No-operation only advances the program counter, by two plus any extension bytes.
// - Byte-count move skips on zero, else copies and steps until zero.
// - Word-count move is the same but counts with sixteen bits.
// - Next instruction is accepted as soon as the last byte is moved.
// - Instructions are built from two-byte units with four field kinds.
// - Leading four bits are the operation; a second field is allowed.
// - Address selectors are three bits, data selectors three or four.
// - Extensions are 8, 16 or 32 bits; 24-bit values have zero top byte.
// - Condition field of a branch selects the evaluated condition.
// - Relative target is sign-extended displacement plus next address.
// - Trap carries a two-bit field choosing the vector address.
`timescale 1ns/1ps
`include "bsd_defines.vh"

module bsd_exec_ctl (
    input wire clk_i,
    input wire nrst_i,
    input wire instr_valid_i,
    input wire [15:0] instr_word_i,
    input wire [31:0] ext_word_i,
    input wire [1:0] ext_size_i,
    input wire [31:0] areg_data_i,
    input wire [7:0] src_data_i,
    input wire flags_we_i,
    input wire [7:0] flags_i,
    input wire wake_i,
    input wire [31:0] blk_src_i,
    input wire [31:0] blk_dst_i,
    input wire [15:0] blk_cnt_i,
    input wire mem_ack_i,
    input wire [15:0] mem_rdata_i,
    output reg instr_ready_o,
    output reg [23:0] pc_o,
    output reg [7:0] ccr_o,
    output reg [7:0] exr_o,
    output reg [2:0] areg_sel_o,
    output reg [3:0] dreg_sel_o,
    output reg branch_taken_o,
    output reg sleep_o,
    output reg store_we_o,
    output reg [7:0] store_data_o,
    output reg blk_we_o,
    output reg [31:0] blk_src_o,
    output reg [31:0] blk_dst_o,
    output reg [15:0] blk_cnt_o,
    output reg mem_req_o,
    output reg mem_we_o,
    output reg mem_word_o,
    output reg [23:0] mem_addr_o,
    output reg [15:0] mem_wdata_o
);
    function [7:0] bsd_logic_op;
        input [3:0] op;
        input [7:0] a;
        input [7:0] b;
        begin
            case (op)
                `BSD_OP_AND_FLAGS: bsd_logic_op = a & b;
                `BSD_OP_OR_FLAGS: bsd_logic_op = a | b;
                default: bsd_logic_op = a ^ b;
            endcase
        end
    endfunction
    reg [2:0] state_r;
    reg [23:0] exc_pc_r;
    reg [7:0] exc_ccr_r;
    reg [23:0] rs_mem_r [0:`BSD_RS_DEPTH-1];
    reg [`BSD_RS_PTR_W-1:0] rs_ptr_r;
    reg sel_ext_r;
    reg [`BSD_RS_PTR_W-1:0] rs_ptr_nxt;
    integer i;
    wire take = instr_valid_i & instr_ready_o;
    wire [3:0] op = instr_word_i[15:12];
    wire [3:0] op2 = instr_word_i[11:8];
    wire [1:0] trap_vec = instr_word_i[1:0];
    wire sel_ext = instr_word_i[`BSD_SEL_EXT_BIT];
    wire sel_mem = instr_word_i[`BSD_SEL_MEM_BIT];
    // Forwarding the flag write keeps a branch from using stale flags.
    wire [7:0] ccr_eff = flags_we_i ? flags_i : ccr_o;
    // An 8-bit extension lives inside the first word; wider ones add words.
    wire [23:0] ext_bytes = (ext_size_i == `BSD_EXT_32) ? `BSD_EXT32_BYTES :
        ((ext_size_i == `BSD_EXT_16) ? `BSD_EXT16_BYTES : 24'h000000);
    wire [23:0] seq_pc = pc_o + `BSD_WORD_BYTES + ext_bytes;
    wire [23:0] disp = (ext_size_i == `BSD_EXT_16) ? {{8{ext_word_i[15]}}, ext_word_i[15:0]} :
        {{16{ext_word_i[7]}}, ext_word_i[7:0]};
    wire [23:0] rel_pc = seq_pc + disp;
    // Top byte of a 24-bit value is zero by format, so only 23..0 is used.
    wire [23:0] abs_pc = (ext_size_i != `BSD_EXT_NONE) ? ext_word_i[23:0] :
        areg_data_i[23:0];
    wire [15:0] cnt_start = (op2 == `BSD_OP2_MOVE_WORD) ? blk_cnt_i : {8'h00, blk_cnt_i[7:0]};
    wire [15:0] cnt_dec = blk_cnt_o - 16'h0001;
    wire cond_true;
    bsd_cond_eval u_cond (
        .cond_i(op2),
        .flags_i(ccr_eff),
        .true_o(cond_true)
    );
    always @* begin
        rs_ptr_nxt = rs_ptr_r;
        if (take && (op == `BSD_OP_CALL_REL || op == `BSD_OP_CALL_ABS)) begin
            rs_ptr_nxt = rs_ptr_r + {{(`BSD_RS_PTR_W-1){1'b0}}, 1'b1};
        end else if (take && op == `BSD_OP_RET_SUB) begin
            rs_ptr_nxt = rs_ptr_r - {{(`BSD_RS_PTR_W-1){1'b0}}, 1'b1};
        end
    end
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_r <= `BSD_ST_READY;
            instr_ready_o <= 1'b1;
            pc_o <= `BSD_PC_RESET;
            ccr_o <= `BSD_CCR_RESET;
            exr_o <= `BSD_EXR_RESET;
            exc_pc_r <= `BSD_PC_RESET;
            exc_ccr_r <= `BSD_CCR_RESET;
            for (i = 0; i < `BSD_RS_DEPTH; i = i + 1) begin
                rs_mem_r[i] <= 24'h000000;
            end
            rs_ptr_r <= {`BSD_RS_PTR_W{1'b0}};
            sel_ext_r <= 1'b0;
            areg_sel_o <= 3'h0;
            dreg_sel_o <= 4'h0;
            branch_taken_o <= 1'b0;
            sleep_o <= 1'b0;
            store_we_o <= 1'b0;
            store_data_o <= 8'h00;
            blk_we_o <= 1'b0;
            blk_src_o <= 32'h00000000;
            blk_dst_o <= 32'h00000000;
            blk_cnt_o <= 16'h0000;
            mem_req_o <= 1'b0;
            mem_we_o <= 1'b0;
            mem_word_o <= 1'b0;
            mem_addr_o <= 24'h000000;
            mem_wdata_o <= 16'h0000;
        end else begin
            branch_taken_o <= 1'b0;
            store_we_o <= 1'b0;
            blk_we_o <= 1'b0;
            rs_ptr_r <= rs_ptr_nxt;
            // Flag-register instructions below override this later in program order.
            if (flags_we_i) begin
                ccr_o <= flags_i;
            end
            case (state_r)
                `BSD_ST_READY: begin
                    if (take) begin
                        areg_sel_o <= instr_word_i[6:4];
                        dreg_sel_o <= instr_word_i[3:0];
                        sel_ext_r <= sel_ext;
                        pc_o <= seq_pc;
                        case (op)
                            `BSD_OP_BRANCH: begin
                                if (cond_true) begin
                                    pc_o <= rel_pc;
                                    branch_taken_o <= 1'b1;
                                end
                            end
                            `BSD_OP_JUMP: begin
                                pc_o <= abs_pc;
                                branch_taken_o <= 1'b1;
                            end
                            `BSD_OP_CALL_REL: begin
                                rs_mem_r[rs_ptr_r] <= seq_pc;
                                pc_o <= rel_pc;
                                branch_taken_o <= 1'b1;
                            end
                            `BSD_OP_CALL_ABS: begin
                                rs_mem_r[rs_ptr_r] <= seq_pc;
                                pc_o <= abs_pc;
                                branch_taken_o <= 1'b1;
                            end
                            `BSD_OP_RET_SUB: begin
                                pc_o <= rs_mem_r[rs_ptr_nxt];
                                branch_taken_o <= 1'b1;
                            end
                            `BSD_OP_TRAP: begin
                                exc_pc_r <= seq_pc;
                                exc_ccr_r <= ccr_eff;
                                mem_req_o <= 1'b1;
                                mem_we_o <= 1'b0;
                                mem_word_o <= 1'b1;
                                mem_addr_o <= `BSD_TRAP_VEC_BASE + {20'h00000, trap_vec, 2'b00};
                                instr_ready_o <= 1'b0;
                                state_r <= `BSD_ST_VEC_RD;
                            end
                            `BSD_OP_RET_EXC: begin
                                pc_o <= exc_pc_r;
                                ccr_o <= exc_ccr_r;
                                branch_taken_o <= 1'b1;
                            end
                            `BSD_OP_SLEEP: begin
                                sleep_o <= 1'b1;
                                instr_ready_o <= 1'b0;
                                state_r <= `BSD_ST_SLEEP;
                            end
                            `BSD_OP_LOAD_FLAGS: begin
                                if (sel_mem) begin
                                    mem_req_o <= 1'b1;
                                    mem_we_o <= 1'b0;
                                    mem_word_o <= 1'b1;
                                    mem_addr_o <= abs_pc;
                                    instr_ready_o <= 1'b0;
                                    state_r <= `BSD_ST_FLAG_RD;
                                end else if (sel_ext) begin
                                    exr_o <= src_data_i;
                                end else begin
                                    ccr_o <= src_data_i;
                                end
                            end
                            `BSD_OP_STORE_FLAGS: begin
                                if (sel_mem) begin
                                    mem_req_o <= 1'b1;
                                    mem_we_o <= 1'b1;
                                    mem_word_o <= 1'b1;
                                    mem_addr_o <= abs_pc;
                                    mem_wdata_o <= {(sel_ext ? exr_o : ccr_eff), 8'h00};
                                    instr_ready_o <= 1'b0;
                                    state_r <= `BSD_ST_FLAG_WR;
                                end else begin
                                    store_data_o <= sel_ext ? exr_o : ccr_eff;
                                    store_we_o <= 1'b1;
                                end
                            end
                            `BSD_OP_AND_FLAGS, `BSD_OP_OR_FLAGS, `BSD_OP_XOR_FLAGS: begin
                                if (sel_ext) begin
                                    exr_o <= bsd_logic_op(op, exr_o, ext_word_i[7:0]);
                                end else begin
                                    ccr_o <= bsd_logic_op(op, ccr_eff, ext_word_i[7:0]);
                                end
                            end
                            `BSD_OP_SECOND: begin
                                if (op2 == `BSD_OP2_MOVE_BYTE || op2 == `BSD_OP2_MOVE_WORD) begin
                                    blk_src_o <= blk_src_i;
                                    blk_dst_o <= blk_dst_i;
                                    blk_cnt_o <= cnt_start;
                                    // A zero count falls through as if it were a no-op.
                                    if (cnt_start != 16'h0000) begin
                                        mem_req_o <= 1'b1;
                                        mem_we_o <= 1'b0;
                                        mem_word_o <= 1'b0;
                                        mem_addr_o <= blk_src_i[23:0];
                                        instr_ready_o <= 1'b0;
                                        state_r <= `BSD_ST_MOVE_RD;
                                    end
                                end
                            end
                            default: ;
                        endcase
                    end
                end
                `BSD_ST_VEC_RD: begin
                    if (mem_ack_i) begin
                        mem_req_o <= 1'b0;
                        pc_o <= {8'h00, mem_rdata_i};
                        branch_taken_o <= 1'b1;
                        instr_ready_o <= 1'b1;
                        state_r <= `BSD_ST_READY;
                    end
                end
                `BSD_ST_FLAG_RD: begin
                    if (mem_ack_i) begin
                        mem_req_o <= 1'b0;
                        if (sel_ext_r) begin
                            exr_o <= mem_rdata_i[15:8];
                        end else begin
                            ccr_o <= mem_rdata_i[15:8];
                        end
                        instr_ready_o <= 1'b1;
                        state_r <= `BSD_ST_READY;
                    end
                end
                `BSD_ST_FLAG_WR: begin
                    if (mem_ack_i) begin
                        mem_req_o <= 1'b0;
                        mem_we_o <= 1'b0;
                        instr_ready_o <= 1'b1;
                        state_r <= `BSD_ST_READY;
                    end
                end
                `BSD_ST_MOVE_RD: begin
                    if (mem_ack_i) begin
                        mem_we_o <= 1'b1;
                        mem_addr_o <= blk_dst_o[23:0];
                        mem_wdata_o <= {8'h00, mem_rdata_i[7:0]};
                        state_r <= `BSD_ST_MOVE_WR;
                    end
                end
                `BSD_ST_MOVE_WR: begin
                    if (mem_ack_i) begin
                        blk_src_o <= blk_src_o + `BSD_PTR_STEP;
                        blk_dst_o <= blk_dst_o + `BSD_PTR_STEP;
                        blk_cnt_o <= cnt_dec;
                        mem_we_o <= 1'b0;
                        if (cnt_dec == 16'h0000) begin
                            mem_req_o <= 1'b0;
                            blk_we_o <= 1'b1;
                            instr_ready_o <= 1'b1;
                            state_r <= `BSD_ST_READY;
                        end else begin
                            mem_addr_o <= blk_src_o[23:0] + 24'h000001;
                            state_r <= `BSD_ST_MOVE_RD;
                        end
                    end
                end
                `BSD_ST_SLEEP: begin
                    if (wake_i) begin
                        sleep_o <= 1'b0;
                        instr_ready_o <= 1'b1;
                        state_r <= `BSD_ST_READY;
                    end
                end
                default: begin
                    mem_req_o <= 1'b0;
                    instr_ready_o <= 1'b1;
                    state_r <= `BSD_ST_READY;
                end
            endcase
        end
    end
endmodule

// ---- verif/bsd_exec_chk_asserts.sv ----
// Port checker of the execution block.
// Assumes it is bound into bsd_exec_ctl and sees only its ports.
`timescale 1ns/1ps
module bsd_exec_chk (
    input wire clk_i,
    input wire nrst_i,
    input wire instr_valid_i,
    input wire [15:0] instr_word_i,
    input wire [1:0] ext_size_i,
    input wire [15:0] blk_cnt_i,
    input wire mem_ack_i,
    input wire instr_ready_o,
    input wire [23:0] pc_o,
    input wire branch_taken_o,
    input wire sleep_o,
    input wire mem_req_o,
    input wire mem_we_o,
    input wire mem_word_o,
    input wire [23:0] mem_addr_o
);
    wire tk = instr_valid_i && instr_ready_o;
    wire [7:0] hi = instr_word_i[15:8];
    wire [1:0] tv = instr_word_i[1:0];
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    a_always_taken: assert property (tk && hi == 8'h00 |=> branch_taken_o)
        else $error("always branch not taken");
    a_never_taken: assert property (tk && hi == 8'h01 |=> !branch_taken_o)
        else $error("never branch taken");
    a_nop_step: assert property (tk && hi[7:4] == 4'hd && ext_size_i == 2'h0
        |=> pc_o == $past(pc_o) + 24'h2) else $error("nop step wrong");
    a_trap_vector: assert property (tk && hi[7:4] == 4'h5 |=> mem_req_o && mem_word_o
        && mem_addr_o == 24'h20 + {$past(tv), 2'h0}) else $error("trap vector wrong");
    a_sleep_enter: assert property (tk && hi[7:4] == 4'h7 |=> sleep_o && !instr_ready_o)
        else $error("sleep not entered");
    a_load_word: assert property (tk && hi[7:4] == 4'h8 && hi[2] && ext_size_i != 2'h0
        |=> mem_req_o && mem_word_o && !mem_we_o) else $error("flag load not word read");
    a_req_hold: assert property (mem_req_o && !mem_ack_i |=> mem_req_o
        && $stable(mem_addr_o) && $stable(mem_we_o)) else $error("request changed early");
    a_zero_move: assert property (tk && hi == 8'hf0 && blk_cnt_i[7:0] == 8'h00
        |=> instr_ready_o && !mem_req_o) else $error("zero move not skipped");
    a_busy_mem: assert property (mem_req_o |-> !instr_ready_o)
        else $error("ready during transfer");
    c_trap: cover property (tk && hi[7:4] == 4'h5);
    c_move: cover property (tk && hi == 8'hf1);
    c_sleep: cover property (sleep_o && !instr_ready_o);
endmodule
bind bsd_exec_ctl bsd_exec_chk i_bsd_exec_chk (.*);

// ---- verif/bsd_mem_model.sv ----
// On-chip memory model answering the execution block.
// Assumes one request at a time, held until its ack.
`timescale 1ns/1ps
module bsd_mem_model (
    input wire clk_i,
    input wire nrst_i,
    input wire slow_i,
    input wire req_i,
    input wire we_i,
    input wire word_i,
    input wire [23:0] addr_i,
    input wire [15:0] wdata_i,
    output reg ack_o,
    output reg [15:0] rdata_o,
    output reg [15:0] wr_o
);
    reg [1:0] wait_r;
    // Data toggles outside an ack so a stale word is never taken for a fresh one.
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ack_o <= 1'b0;
            wait_r <= 2'h0;
            rdata_o <= 16'h0000;
            wr_o <= 16'h0000;
        end else begin
            ack_o <= 1'b0;
            rdata_o <= ~rdata_o;
            if (req_i && !ack_o && wait_r != {slow_i, 1'b0}) wait_r <= wait_r + 2'h1;
            else if (req_i && !ack_o) begin
                ack_o <= 1'b1;
                wait_r <= 2'h0;
                rdata_o <= word_i ? {addr_i[7:0] ^ 8'ha5, addr_i[7:0]} : {2{addr_i[7:0] ^ 8'h5a}};
                if (we_i) wr_o <= wdata_i;
            end
        end
    end
endmodule

// ---- verif/bsd_exec_ctl_test.sv ----
// Bench of the execution block against the memory model.
// Assumes the design, the model and the checker are compiled first.
`timescale 1ns/1ps
module bsd_exec_ctl_test;
    reg clk_i = '0, nrst_i = '0, instr_valid_i = '0, flags_we_i = '0, wake_i = '0, slow = '0;
    reg [15:0] instr_word_i = '0, blk_cnt_i = '0;
    reg [31:0] ext_word_i = '0, areg_data_i = '0, blk_src_i = 32'h100, blk_dst_i = 32'h200;
    reg [1:0] ext_size_i = '0;
    reg [7:0] src_data_i = '0, flags_i = '0, ec, ee = '0, m, r, c0;
    reg [23:0] ep = '0, p0;
    integer failures = 0, cmp_count = 0, cyc = 0, i, j;
    wire instr_ready_o, branch_taken_o, sleep_o, store_we_o, blk_we_o, mem_ack_i;
    wire mem_req_o, mem_we_o, mem_word_o;
    wire [2:0] areg_sel_o;
    wire [3:0] dreg_sel_o;
    wire [7:0] ccr_o, exr_o, store_data_o;
    wire [15:0] blk_cnt_o, mem_rdata_i, mem_wdata_o, wr;
    wire [23:0] pc_o, mem_addr_o;
    wire [31:0] blk_src_o, blk_dst_o;
    bsd_exec_ctl i_bsd_exec_ctl (.*);
    bsd_mem_model i_bsd_mem_model (.clk_i(clk_i), .nrst_i(nrst_i), .slow_i(slow),
        .req_i(mem_req_o), .we_i(mem_we_o), .word_i(mem_word_o), .addr_i(mem_addr_o),
        .wdata_i(mem_wdata_o), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i), .wr_o(wr));
    task report_and_stop;
        if (failures == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task cmp(input [63:0] g, input [63:0] e);
        cmp_count = cmp_count + 1;
        if (g !== e) begin
            failures = failures + 1;
            $display("mismatch at %0t got %h exp %h", $time, g, e);
        end
    endtask
    // Called at a falling edge with the block ready; ep tracks the sequential address.
    // Valid stays up, so the next word must be issued before another edge passes.
    task issue(input [15:0] w, input [31:0] e, input [1:0] s);
        {instr_word_i, ext_word_i, ext_size_i, instr_valid_i} = {w, e, s, 1'b1};
        @(negedge clk_i);
        ep = ep + 24'h2 + (s == 2'h2 ? 24'h2 : s == 2'h3 ? 24'h4 : 24'h0);
    endtask
    task wrdy;
        integer k;
        for (k = 0; k < 3000 && instr_ready_o !== 1'b1; k = k + 1) @(negedge clk_i);
    endtask
    function t(input [3:0] c, input [3:0] f);
        reg [7:0] v;
        v = ~{f[2] | (f[3] ^ f[1]), f[3] ^ f[1], f[3], f[1], f[2], f[0], f[0] | f[2], 1'b0};
        t = v[c[3:1]] ^ c[0];
    endfunction
    task t_branch;
        for (i = 0; i < 256; i = i + 1) begin
            {flags_we_i, flags_i, ec} = {1'b1, 4'h0, i[7:4], 4'h0, i[7:4]};
            issue({4'h0, i[3:0], 8'h00}, 32'hf0, 2'h1);
            cmp(branch_taken_o, t(i[3:0], i[7:4]));
            if (t(i[3:0], i[7:4])) ep = ep - 24'h10;
            cmp(pc_o, ep);
            cmp(ccr_o, ec);
        end
        flags_we_i = 1'b0;
    endtask
    task t_jump;
        issue(16'h1000, 32'h12344, 2'h3);
        cmp(pc_o, 24'h12344);
        issue(16'h2000, 32'hfff0, 2'h2);
        cmp(pc_o, 24'h12338);
        areg_data_i = 32'h400;
        issue(16'h3000, '0, 2'h0);
        cmp(pc_o, 24'h400);
        issue(16'h4000, '0, 2'h0);
        cmp(pc_o, 24'h1233a);
        issue(16'h4000, '0, 2'h0);
        ep = 24'h12348;
        cmp(pc_o, ep);
    endtask
    task t_flags;
        for (i = 0; i < 6; i = i + 1) begin
            j = i % 3;
            m = 8'h3c + i[7:0];
            issue({4'ha + j[3:0], i > 2, 11'h0}, {24'h0, m}, 2'h1);
            r = (i > 2) ? ee : ec;
            r = j == 0 ? r & m : j == 1 ? r | m : r ^ m;
            if (i > 2) ee = r;
            else ec = r;
            cmp({exr_o, ccr_o}, {ee, ec});
        end
        issue(16'hd05a, '0, 2'h0);
        cmp({pc_o, ccr_o, exr_o}, {ep, ec, ee});
        cmp({areg_sel_o, dreg_sel_o}, {3'h5, 4'ha});
        issue(16'h9800, '0, 2'h0);
        cmp({store_we_o, store_data_o}, {1'b1, ee});
        src_data_i = 8'ha6;
        issue(16'h8000, '0, 2'h0);
        cmp(ccr_o, 8'ha6);
        issue(16'h8400, 32'h1234, 2'h2);
        wrdy;
        cmp(ccr_o, 8'h91);
        issue(16'h9400, 32'h2000, 2'h2);
        wrdy;
        cmp(wr, 16'h9100);
    endtask
    task t_sys;
        slow = 1'b1;
        c0 = 8'h91;
        issue(16'h5002, '0, 2'h0);
        p0 = ep;
        wrdy;
        cmp(pc_o, 24'h8d28);
        issue(16'ha000, '0, 2'h1);
        issue(16'h6000, '0, 2'h0);
        cmp({pc_o, ccr_o}, {p0, c0});
        ep = p0;
        issue(16'h7000, '0, 2'h0);
        repeat (3) @(negedge clk_i);
        cmp({sleep_o, instr_ready_o}, 2'h2);
        wake_i = 1'b1;
        @(negedge clk_i);
        wake_i = 1'b0;
        cmp({sleep_o, pc_o}, {1'b0, ep});
    endtask
    task mv(input [3:0] v, input [15:0] c, input [15:0] n);
        blk_cnt_i = c;
        issue({4'hf, v, 8'h0}, '0, 2'h0);
        wrdy;
        cmp({blk_we_o, pc_o}, {n != 0, ep});
        if (n != 0) begin
            cmp(blk_cnt_o & (v[0] ? 16'hffff : 16'h00ff), '0);
            cmp({blk_src_o, blk_dst_o}, {32'h100 + n, 32'h200 + n});
            cmp(wr, {8'h00, (n[7:0] - 8'h1) ^ 8'h5a});
        end
    endtask
    initial forever #25 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            failures = failures + 1;
            report_and_stop;
        end
    end
    initial begin
        repeat (16) @(negedge clk_i);
        nrst_i = 1'b1;
        @(negedge clk_i);
        t_branch;
        t_jump;
        t_flags;
        t_sys;
        mv(4'h0, 16'h0103, 16'h3);
        mv(4'h0, 16'h0100, 16'h0);
        slow = 1'b0;
        mv(4'h1, 16'h0101, 16'h101);
        report_and_stop;
    end
endmodule
